// File: hw/adcs_clkdiv.sv
/*
  Conversion clock divider: a one-cycle tick every 2**code system clocks.
  Assumes one system clock and a synchronous active-high reset.
*/
module adcs_clkdiv #(
  parameter int DIV_W = 3
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [DIV_W-1:0] div_code,
  output logic tick
);
  import adcs_pkg::*;

  // Counter must cover the largest ratio
  if (DIV_W != 3) begin : g_chk
    $error("adcs_clkdiv: DIV_W must be 3");
  end

  adcs_div_s q_reg; // Registered state
  adcs_div_s q_next; // Next state
  logic [6:0] mask; // Low bits that must be all ones

  // Mask of 2**code - 1 and the free-running count
  always_comb begin
    mask = 7'(({7'h00, 1'b1} << div_code) - 8'h01);
    q_next = q_reg;
    q_next.cnt = q_reg.cnt + 7'h01;
  end

  // Tick when all masked bits are set; code 0 ticks every cycle
  assign tick = ((q_reg.cnt & mask) == mask);

  // State register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

endmodule : adcs_clkdiv

// File: hw/adcs_top.sv
/*
  Converter control sequencer: control registers, input and reference
  routing, conversion clock, sample/convert sequencing with a
  successive-approximation search, result formatting and the done event.
  Assumes a comparator answer that is valid one system clock after the
  trial code changes, and a processor interrupt controller that owns the
  interrupt request flag and its enable.
*/
// Implementation choices: the strobed register port and the register offsets.
//
// Summary of operation
// - Decode source field onto analog input switches
// - Decode reference field onto reference switches
// - Conversion clock is system clock over 2**code
// - Bandgap enable bit; off means output high-impedance
// - Gain bit resets to one, kept one; the code lets a write of bit 1 of the sensor register clear it
// - Unimplemented control bits read as zero
// - Calibration value split across two read registers
// - Start pulse low-high-low launches a conversion
// - Busy set on launch, cleared on completion
// - Completion raises interrupt request event
// - External inputs: 4 sample, 12 convert clocks
// - Sensor input: 46 sample, 12 convert clocks
// - Justify bit aligns result left or right
`include "adcs_cfg.svh"

module adcs_top #(
  parameter int CNT_W = 6
) (
  input wire logic clk_sys,
  input wire logic srst,
  input adcs_pkg::adcs_bus_s bus,
  output logic [7:0] rdata,
  input wire logic [11:0] cal_85c_value,
  input wire logic comp_in,
  output adcs_pkg::adcs_ana_s ana,
  output logic irq_req
);
  import adcs_pkg::*;

  // The sample count must hold the longest sampling phase
  if (CNT_W < 6) begin : g_chk
    $error("adcs_top: CNT_W must be at least 6");
  end

  adcs_state_s q_reg; // Registered state
  adcs_state_s q_next; // Next state
  logic ck_tick; // One-cycle conversion clock tick
  logic wr0; // Write to adc_control_0
  logic launch; // Conversion launch this cycle
  logic pwr; // Converter power enable after this cycle
  logic [5:0] samp_len; // Sampling length of this conversion
  logic [3:0] bit_idx; // Bit under trial
  logic [11:0] trial; // Search code after this step
  logic [7:0] res_hi; // Formatted high result byte
  logic [7:0] res_lo; // Formatted low result byte
  logic [7:0] rd_mux; // Read data before the register

  // Conversion clock from the divider field
  adcs_clkdiv #(
    .DIV_W(3)
  ) u_div (
    .clk_sys(clk_sys),
    .srst(srst),
    .div_code(q_reg.ctl1[2:0]),
    .tick(ck_tick)
  );

  // Input source decode; the forbidden code opens every switch
  function automatic adcs_route_s route_of(input logic [2:0] code);
    adcs_route_s r;
    r = '0;
    unique case (adcs_src_e'(code))
      SRC_EXT, SRC_EXT2: r.ext_channel = 1'b1;
      SRC_BGAP: r.bandgap_voltage = 1'b1;
      SRC_SENS: r.sensor_output_voltage = 1'b1;
      SRC_AMP0: r.amp0_output = 1'b1;
      SRC_AMP1: r.amp1_output = 1'b1;
      SRC_LINE: r.line_amp_output = 1'b1;
      SRC_BAD: r = '0;
    endcase
    return r;
  endfunction : route_of

  // Reference decode
  function automatic adcs_ref_s ref_of(input logic [1:0] code);
    adcs_ref_s r;
    r = '0;
    unique case (code)
      2'h0: r.ext_pin = 1'b1;
      2'h1, 2'h3: r.supply = 1'b1;
      2'h2: r.sensor_reference_voltage = 1'b1;
    endcase
    return r;
  endfunction : ref_of

  // Result alignment chosen by the justify bit
  always_comb begin
    if (q_reg.ctl0[`ADCS_C0_JUST]) begin
      res_hi = {4'h0, q_reg.res[11:8]};
      res_lo = q_reg.res[7:0];
    end else begin
      res_hi = q_reg.res[11:4];
      res_lo = {q_reg.res[3:0], 4'h0};
    end
  end

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    unique case (bus.addr)
      `ADCS_OFF_CTL0: begin
        rd_mux = q_reg.ctl0;
        rd_mux[`ADCS_C0_BUSY] = q_reg.busy;
      end
      `ADCS_OFF_CTL1: rd_mux = q_reg.ctl1;
      `ADCS_OFF_BGAP: rd_mux = {7'h00, q_reg.bg_en};
      `ADCS_OFF_SENS: rd_mux = {6'h00, q_reg.gain, q_reg.ts_en};
      `ADCS_OFF_CALH: rd_mux = cal_85c_value[11:4];
      `ADCS_OFF_CALL: rd_mux = {cal_85c_value[3:0], 4'h0};
      `ADCS_OFF_RESH: rd_mux = res_hi;
      `ADCS_OFF_RESL: rd_mux = res_lo;
      default: rd_mux = 8'h00;
    endcase
  end

  // Write decode and start detection
  always_comb begin
    wr0 = bus.wr && (bus.addr == `ADCS_OFF_CTL0);
    pwr = wr0 ? bus.wdata[`ADCS_C0_PWR] : q_reg.ctl0[`ADCS_C0_PWR];
    // Falling edge of a start bit that was written high before
    launch = wr0 && q_reg.ctl0[`ADCS_C0_START] &&
             !bus.wdata[`ADCS_C0_START] && pwr && !q_reg.busy;
  end

  // Sampling length and successive-approximation step
  always_comb begin
    samp_len = q_reg.ts_conv ? `ADCS_SAMP_TS : `ADCS_SAMP_EXT;
    bit_idx = 4'(4'hb - q_reg.cnt[3:0]);
    trial = q_reg.sar;
    // Comparator low means the trial overshot: drop the bit
    if (!comp_in) begin
      trial[bit_idx] = 1'b0;
    end
    // Put the next lower bit on trial
    if (bit_idx != 4'h0) begin
      trial[bit_idx - 4'h1] = 1'b1;
    end
  end

  // Next state
  always_comb begin
    q_next = q_reg;
    q_next.done = 1'b0;
    q_next.rdata = bus.rd ? rd_mux : 8'h00;

    // Register writes; busy is not writable
    if (wr0) begin
      q_next.ctl0 = bus.wdata;
      q_next.ctl0[`ADCS_C0_BUSY] = 1'b0;
    end
    if (bus.wr && bus.addr == `ADCS_OFF_CTL1) begin
      q_next.ctl1 = bus.wdata;
    end
    if (bus.wr && bus.addr == `ADCS_OFF_BGAP) begin
      q_next.bg_en = bus.wdata[0];
    end
    if (bus.wr && bus.addr == `ADCS_OFF_SENS) begin
      q_next.ts_en = bus.wdata[0];
      q_next.gain = bus.wdata[1];
    end

    // Registered routing follows the control fields
    q_next.route = route_of(q_next.ctl1[7:5]);
    q_next.refs = ref_of(q_next.ctl1[4:3]);

    // Sequencer
    unique case (q_reg.st)
      ST_IDLE: begin
        // Launch on the falling edge of the start bit
        if (launch) begin
          q_next.busy = 1'b1;
          q_next.st = ST_SAMPLE;
          q_next.cnt = 6'h00;
          q_next.ts_conv = (q_reg.ctl1[7:5] == SRC_SENS);
          q_next.sar = 12'h800;
        end
      end
      ST_SAMPLE: begin
        // Hold the sampling switch for the sampling phase
        if (ck_tick) begin
          if (q_reg.cnt == 6'(samp_len - 6'h01)) begin
            q_next.st = ST_CONVERT;
            q_next.cnt = 6'h00;
          end else begin
            q_next.cnt = q_reg.cnt + 6'h01;
          end
        end
      end
      ST_CONVERT: begin
        // One result bit per conversion clock
        if (ck_tick) begin
          q_next.sar = trial;
          if (q_reg.cnt == 6'(`ADCS_CONV_BITS - 6'h01)) begin
            q_next.res = trial;
            q_next.busy = 1'b0;
            q_next.done = 1'b1;
            q_next.st = ST_IDLE;
            q_next.cnt = 6'h00;
          end else begin
            q_next.cnt = q_reg.cnt + 6'h01;
          end
        end
      end
      default: begin
        q_next.st = ST_IDLE;
        q_next.busy = 1'b0;
      end
    endcase

    // Powering down aborts; the result stays unchanged
    if (!pwr && q_reg.st != ST_IDLE) begin
      q_next.res = q_reg.res;
      q_next.st = ST_IDLE;
      q_next.busy = 1'b0;
      q_next.done = 1'b0;
      q_next.cnt = 6'h00;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q_reg <= '0;
      q_reg.ctl0 <= `ADCS_CTL0_RST;
      q_reg.ctl1 <= `ADCS_CTL1_RST;
      q_reg.bg_en <= `ADCS_BGAP_RST;
      q_reg.ts_en <= `ADCS_SENS_EN_RST;
      q_reg.gain <= `ADCS_GAIN_RST;
      q_reg.st <= ST_IDLE;
      q_reg.route.ext_channel <= 1'b1;
      q_reg.refs.ext_pin <= 1'b1;
    end else begin
      q_reg <= q_next;
    end
  end

  // Outputs
  assign rdata = q_reg.rdata;
  assign irq_req = q_reg.done;

  // Analog control bundle
  always_comb begin
    ana.route = q_reg.route;
    ana.refs = q_reg.refs;
    ana.channel_select = q_reg.ctl0[3:0];
    ana.converter_power_enable = q_reg.ctl0[`ADCS_C0_PWR];
    ana.bandgap_enable = q_reg.bg_en;
    ana.bandgap_hiz = !q_reg.bg_en;
    ana.sensor_enable = q_reg.ts_en;
    ana.reserved_gain_bit = q_reg.gain;
    ana.sample_en = (q_reg.st == ST_SAMPLE);
    ana.dac_code = q_reg.sar;
  end

endmodule : adcs_top

// File: pkg/adcs_cfg.svh
/*
  Offsets, field positions, reset values and cycle counts of the
  converter control sequencer.
  Assumes it is included by bare name wherever these are needed.
*/
`ifndef ADCS_CFG_SVH
`define ADCS_CFG_SVH

// Register offsets on the plain register port
`define ADCS_OFF_CTL0 4'h0
`define ADCS_OFF_CTL1 4'h1
`define ADCS_OFF_BGAP 4'h2
`define ADCS_OFF_SENS 4'h3
`define ADCS_OFF_CALH 4'h4
`define ADCS_OFF_CALL 4'h5
`define ADCS_OFF_RESH 4'h6
`define ADCS_OFF_RESL 4'h7

// Field positions in adc_control_0
`define ADCS_C0_START 7
`define ADCS_C0_BUSY 6
`define ADCS_C0_PWR 5
`define ADCS_C0_JUST 4

// Reset values
`define ADCS_CTL0_RST 8'h00
`define ADCS_CTL1_RST 8'h00
`define ADCS_BGAP_RST 1'b0
`define ADCS_SENS_EN_RST 1'b0
`define ADCS_GAIN_RST 1'b1

// Conversion clock counts
`define ADCS_SAMP_EXT 6'h04
`define ADCS_SAMP_TS 6'h2e
`define ADCS_CONV_BITS 6'h0c

`endif

// File: pkg/adcs_pkg.sv
/*
  Types of the converter control sequencer.
  Assumes adcs_cfg.svh is compiled alongside for the numeric constants.
*/
package adcs_pkg;

  // Sequencer phase, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONVERT = 3'b100
  } adcs_st_e;

  // Input source codes of the three-bit field
  typedef enum logic [2:0] {
    SRC_EXT = 3'h0,
    SRC_BGAP = 3'h1,
    SRC_SENS = 3'h2,
    SRC_AMP0 = 3'h3,
    SRC_AMP1 = 3'h4,
    SRC_LINE = 3'h5,
    SRC_EXT2 = 3'h6,
    SRC_BAD = 3'h7
  } adcs_src_e;

  // Analog input routing switches, one-hot or all off
  typedef struct packed {
    logic ext_channel;
    logic bandgap_voltage;
    logic sensor_output_voltage;
    logic amp0_output;
    logic amp1_output;
    logic line_amp_output;
  } adcs_route_s;

  // Reference routing switches
  typedef struct packed {
    logic ext_pin;
    logic supply;
    logic sensor_reference_voltage;
  } adcs_ref_s;

  // Analog control bundle towards the converter core
  typedef struct packed {
    adcs_route_s route;
    adcs_ref_s refs;
    logic [3:0] channel_select;
    logic converter_power_enable;
    logic bandgap_enable;
    logic bandgap_hiz;
    logic sensor_enable;
    logic reserved_gain_bit;
    logic sample_en;
    logic [11:0] dac_code;
  } adcs_ana_s;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } adcs_bus_s;

  // Divider state
  typedef struct packed {
    logic [6:0] cnt;
  } adcs_div_s;

  // Whole sequencer state
  typedef struct packed {
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic bg_en;
    logic ts_en;
    logic gain;
    logic busy;
    adcs_st_e st;
    logic [5:0] cnt;
    logic ts_conv;
    logic [11:0] sar;
    logic [11:0] res;
    logic [7:0] rdata;
    logic done;
    adcs_route_s route;
    adcs_ref_s refs;
  } adcs_state_s;

endpackage : adcs_pkg

// File: test/adcs_analog_model.sv
/*
  Analog far side: input levels and the comparator.
  Assumes route bits are one-hot or all off, as the sequencer drives them.
*/
module adcs_analog_model (
  input wire logic clk_sys,
  input adcs_pkg::adcs_ana_s ana,
  input wire logic [5:0][11:0] lvl,
  output logic comp_in
);
  timeunit 1ns;
  timeprecision 1ns;
  import adcs_pkg::*;
  logic flt_reg = 1'b0; // Floating node wanders every cycle
  logic [11:0] vin; // Selected input level
  logic open_in; // No source joined to the converter
  // Floating input toggles so an open switch never looks valid
  always_ff @(posedge clk_sys) begin
    flt_reg <= !flt_reg;
  end
  // Closed switch selects its level; comparator trials against it
  always_comb begin
    vin = 12'h000;
    open_in = 1'b1;
    for (int i = 0; i < 6; i++) begin
      if (ana.route[i]) begin
        vin = lvl[i];
        open_in = 1'b0;
      end
    end
    if (ana.route.bandgap_voltage && ana.bandgap_hiz) begin
      open_in = 1'b1;
    end
    comp_in = open_in ? flt_reg : (vin >= ana.dac_code);
  end
endmodule : adcs_analog_model

// File: test/adcs_properties.sv
/*
  Port-level assertions for adcs_top, bound into every instance.
  Assumes adcs_pkg is compiled first and one system clock domain.
*/
module adcs_properties (
  input wire logic clk_sys,
  input wire logic srst,
  input adcs_pkg::adcs_bus_s bus,
  input wire logic [7:0] rdata,
  input wire logic [11:0] cal_85c_value,
  input wire logic comp_in,
  input adcs_pkg::adcs_ana_s ana,
  input wire logic irq_req
);
  timeunit 1ns;
  timeprecision 1ns;
  import adcs_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // Write to the second control register
  wire w1 = bus.wr && bus.addr == 4'h1;
  // Write that drops start with power on
  wire go = bus.wr && bus.addr == 4'h0 && !bus.wdata[7] && bus.wdata[5];
  // Cycles since sampling ended, saturating
  logic [9:0] cnv_reg;
  // Counter restarts during every sampling phase
  always_ff @(posedge clk_sys) begin
    if (srst || ana.sample_en) begin
      cnv_reg <= 10'h000;
    end else if (cnv_reg != 10'h3ff) begin
      cnv_reg <= cnv_reg + 10'h001;
    end
  end
  // Sampling phase lasts at least four system clocks
  sequence s_samp;
    ana.sample_en [*4];
  endsequence
  // Completion event drops after one cycle
  sequence s_done;
    ##1 !irq_req;
  endsequence
  src_decode_a: assert property (w1 |=> ana.route ==
    ($past(bus.wdata[7:5]) == 3'h6 ? 6'h20 : 6'h20 >> $past(bus.wdata[7:5])))
    else $error("input switch decode wrong");
  ref_decode_a: assert property (w1 |=> ana.refs ==
    ($past(bus.wdata[4:3]) == 2'h3 ? 3'h2 : 3'h4 >> $past(bus.wdata[4:3])))
    else $error("reference switch decode wrong");
  bgap_hiz_a: assert property (bus.wr && bus.addr == 4'h2 |=>
    ana.bandgap_hiz == !$past(bus.wdata[0])) else $error("bandgap hiz wrong");
  cal_high_a: assert property (bus.rd && bus.addr == 4'h4 |=>
    rdata == $past(cal_85c_value[11:4])) else $error("cal high wrong");
  cal_low_a: assert property (bus.rd && bus.addr == 4'h5 |=>
    rdata == {$past(cal_85c_value[3:0]), 4'h0}) else $error("cal low wrong");
  unimpl_zero_a: assert property (bus.rd && bus.addr == 4'h3 |=>
    rdata[7:2] == 6'h00) else $error("unused sensor bits set");
  launch_cause_a: assert property ($rose(ana.sample_en) |->
    $past(go)) else $error("sampling without start");
  samp_len_a: assert property ($rose(ana.sample_en) |-> s_samp)
    else $error("sampling too short");
  conv_len_a: assert property (irq_req |-> cnv_reg >= 10'h00b &&
    !ana.sample_en) else $error("conversion too short");
  irq_pulse_a: assert property (irq_req |-> s_done)
    else $error("completion event too long");
  gain_reset_a: assert property ($past(srst) |->
    ana.reserved_gain_bit && ana.route == 6'h20) else $error("reset wrong");
endmodule : adcs_properties

bind adcs_top adcs_properties u_props (.clk_sys, .srst, .bus, .rdata,
  .cal_85c_value, .comp_in, .ana, .irq_req);

// File: test/adcs_top_tb_top.sv
/*
  Self-checking bench for adcs_top: registers, routing, conversions.
  Assumes package, design, checker and analog model compiled first.
*/
`include "adcs_cfg.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
  num_errors++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end

module adcs_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import adcs_pkg::*;
  localparam int SETTLE_CYC = 20; // Sensor and power-up wait
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  adcs_bus_s bus = '0;
  logic [7:0] rdata;
  logic [11:0] cal = 12'ha5c;
  logic comp_in;
  adcs_ana_s ana;
  logic irq_req;
  logic [5:0][11:0] lvl = {12'h9c3, 12'h6a1, 12'h2f0, 12'h333, 12'h5e7,
    12'h80f};
  int num_errors = 0;
  int tests_run = 0;
  int n_irq = 0; // Completion events seen after an abort

  adcs_top dut (.clk_sys, .srst, .bus, .rdata, .cal_85c_value(cal),
    .comp_in, .ana, .irq_req);
  adcs_analog_model u_model (.clk_sys, .ana, .lvl, .comp_in);

  // System clock, 100 MHz
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // One write, then an idle cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus <= '0;
    @(posedge clk_sys);
  endtask : wr

  // One read; data stands in the following cycle only
  task automatic chkrd(input logic [3:0] a, input logic [7:0] e);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    #1;
    `CHK(rdata, e)
    @(posedge clk_sys);
  endtask : chkrd

  // Start, watch busy, wait for completion, check result bytes
  task automatic conv(input logic [2:0] s, input logic [2:0] k,
    input logic j);
    logic [11:0] v;
    logic [3:0] ch;
    int p;
    int n;
    v = lvl[5 - s];
    ch = (s == 3'h0) ? 4'h1 : 4'hc;
    p = ((s == 3'h2) ? 58 : 16) << k;
    n = 0;
    // Supply reference; the reference pin keeps its other function
    wr(`ADCS_OFF_CTL1, {s, 2'h1, k});
    wr(`ADCS_OFF_CTL0, {3'h5, j, ch});
    wr(`ADCS_OFF_CTL0, {3'h1, j, ch});
    chkrd(`ADCS_OFF_CTL0, {3'h3, j, ch});
    `CHK(ana.channel_select, ch)
    while (irq_req !== 1'b1 && n < 20000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    @(posedge clk_sys);
    `CHK(n + 3 > p - (1 << k) && n + 3 <= p, 1'b1)
    chkrd(`ADCS_OFF_CTL0, {3'h1, j, ch});
    chkrd(`ADCS_OFF_RESH, j ? {4'h0, v[11:8]} : v[11:4]);
    chkrd(`ADCS_OFF_RESL, j ? v[7:0] : {v[3:0], 4'h0});
  endtask : conv

  // Counts, verdict, end of run
  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Watchdog, well beyond the expected run
  initial begin
    #400000;
    num_errors++;
    wrap_up();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    `CHK(ana.reserved_gain_bit, 1'b1)
    chkrd(`ADCS_OFF_SENS, 8'h02);
    chkrd(`ADCS_OFF_CALH, 8'ha5);
    wr(`ADCS_OFF_CALL, 8'hff);
    chkrd(`ADCS_OFF_CALL, 8'hc0);
    chkrd(4'h9, 8'h00);
    wr(`ADCS_OFF_BGAP, 8'hff);
    chkrd(`ADCS_OFF_BGAP, 8'h01);
    `CHK(ana.bandgap_hiz, 1'b0)
    `CHK(ana.bandgap_enable, 1'b1)
    for (int s = 0; s < 7; s++) begin
      wr(`ADCS_OFF_CTL1, {s[2:0], s[1:0], 3'h0});
      `CHK(ana.route, s == 6 ? 6'h20 : 6'h20 >> s)
      `CHK(ana.refs, s[1:0] == 2'h3 ? 3'h2 : 3'h4 >> s[1:0])
    end
    wr(`ADCS_OFF_CTL0, 8'h80);
    wr(`ADCS_OFF_CTL0, 8'h00);
    chkrd(`ADCS_OFF_CTL0, 8'h00);
    wr(`ADCS_OFF_CTL0, 8'h20);
    repeat (SETTLE_CYC) @(posedge clk_sys);
    `CHK(ana.converter_power_enable, 1'b1)
    conv(3'h0, 3'h6, 1'b0);
    conv(3'h1, 3'h6, 1'b1);
    wr(`ADCS_OFF_SENS, 8'h03);
    repeat (SETTLE_CYC) @(posedge clk_sys);
    `CHK(ana.sensor_enable, 1'b1)
    conv(3'h2, 3'h7, 1'b0);
    conv(3'h5, 3'h6, 1'b1);
    // Launch, then drop power: busy clears, no event, result kept
    wr(`ADCS_OFF_CTL0, 8'hbc);
    wr(`ADCS_OFF_CTL0, 8'h3c);
    wr(`ADCS_OFF_CTL0, 8'h1c);
    chkrd(`ADCS_OFF_CTL0, 8'h1c);
    `CHK(ana.converter_power_enable, 1'b0)
    repeat (1100) begin
      @(posedge clk_sys);
      n_irq += int'(irq_req === 1'b1);
    end
    `CHK(n_irq, 0)
    chkrd(`ADCS_OFF_RESL, 8'h0f);
    wrap_up();
  end
endmodule : adcs_top_tb_top
